/* File: cnss_pkg.sv */
package cnss_pkg;
	// Die geometry: four sides, one of them without clock pins
	localparam int NUM_SIDES       = 4;
	localparam int PINS_PER_SIDE   = 4;
	localparam int PINLESS_SIDE    = 0;
	localparam int CENTER_REF_SIDE = 2;
	// Corner PLLs sit between two sides, centre PLLs take one pin group
	localparam int NUM_CORNER      = 4;
	localparam int NUM_CENTER      = 2;
	localparam int NUM_PLL         = NUM_CORNER + NUM_CENTER;
	localparam int CNT_PER_PLL     = 7;
	// Post-scaler counter indices inside one PLL
	localparam int POST_SCALER_OUT_0 = 0;
	localparam int POST_SCALER_OUT_1 = 1;
	localparam int POST_SCALER_OUT_2 = 2;
	localparam int POST_SCALER_OUT_3 = 3;
	localparam int POST_SCALER_OUT_4 = 4;
	localparam int POST_SCALER_OUT_5 = 5;
	localparam int POST_SCALER_OUT_6 = 6;
	// Reach of one PLL onto the networks
	localparam int PLL_MAX_GLB     = 8;
	localparam int PLL_MAX_REG     = 24;
	// Global selector: four inputs, 2-bit select
	localparam int GSEL_W          = 2;
	localparam int GSEL_IN         = 4;
	// Regional selector: eight candidates, 3-bit static select
	localparam int RSEL_W          = 3;
	localparam int RSEL_IN         = 8;
	// Global route word: four 2-bit fields, one per selector input
	localparam int ROUTE_W         = 8;
	localparam int FLD_IN0         = 0;
	localparam int FLD_IN1         = 2;
	localparam int FLD_IN2         = 4;
	localparam int FLD_IN3         = 6;
	localparam int FLD_W           = 2;
	// PLL dedicated output counter select width
	localparam int PCNT_W          = 3;
	// Reset level of every control and output flop
	localparam logic RST_LVL       = 1'b0;
endpackage

/* File: cnss_net_if.sv */
`timescale 1ns/1ps
// Ties one source selector to one enable gate
interface cnss_net_if;
	logic src;      // Selected source level
	logic used;     // Network in use
	logic ena;      // Dynamic enable
	logic bypass;   // Skip extra enable stage
	logic net;      // Gated network
	logic en_state; // Enable as seen by the gate
	modport mux  (output src);
	modport gate (input src, used, ena, bypass, output net, en_state);
	modport ctl  (output used, ena, bypass, input net, en_state);
	modport drv  (output src, used, ena, bypass, input net, en_state);
endinterface

/* File: cnss_src_mux.sv */
`timescale 1ns/1ps
module cnss_src_mux
	import cnss_pkg::*;
#(
	parameter int N_IN   = GSEL_IN, // Candidate count
	parameter int SEL_W  = GSEL_W,  // Select width
	parameter bit DYN_OK = 1'b1     // Run-time select allowed
)(
	input  wire logic             clk,        // System clock
	input  wire logic             rst_n,      // Sync reset, low
	input  wire logic [N_IN-1:0]  cand,       // Candidate sources
	input  wire logic [SEL_W-1:0] static_sel, // Configured select
	input  wire logic [SEL_W-1:0] dyn_sel,    // Fabric select
	input  wire logic             dyn_mode,   // Configured for run time
	input  wire logic             user_mode,  // Device in user mode
	cnss_net_if.mux               nif         // Selected source out
);
	logic [SEL_W-1:0] eff_sel;
	logic             dyn_live;
	logic             static_pick;
	logic             dyn_pick;
	logic             src_r;

	if (N_IN != 2 ** SEL_W)
	begin : g_bad_width
		$error("cnss_src_mux: N_IN must equal 2**SEL_W");
	end

	// Fabric select counts only once the device runs the user design
	assign dyn_live = DYN_OK && dyn_mode && user_mode; // [RL3] [RL10] [RL20]
	assign eff_sel  = dyn_live ? dyn_sel : static_sel; // [RL2] [RL8]
	assign static_pick = cand[static_sel];
	assign dyn_pick    = cand[dyn_sel];

	// Registered pick keeps the selector glitch free
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			src_r <= RST_LVL;
		else
			src_r <= cand[eff_sel]; // [RL2]
	end

	assign nif.src = src_r;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	static_hold_a: assert property (!user_mode |=> nif.src == $past(static_pick)) // [RL20]
		else $error("source left static pick before user mode");
	dyn_take_a: assert property (dyn_live |=> nif.src == $past(dyn_pick)) // [RL3]
		else $error("run-time select not followed");
	fixed_sel_a: assert property (!DYN_OK |=> nif.src == $past(static_pick)) // [RL10]
		else $error("fixed selector followed fabric select");

endmodule // cnss_src_mux

/* File: cnss_gate.sv */
`timescale 1ns/1ps
module cnss_gate
	import cnss_pkg::*;
#(
	parameter bit HAS_BYPASS = 1'b1 // Extra stage may be skipped
)(
	input  wire logic clk,   // System clock
	input  wire logic rst_n, // Sync reset, low
	cnss_net_if.gate  nif    // Source, controls, gated net
);
	logic ena_s_r;
	logic ena_in;
	logic src_d_r;
	logic fall;
	logic en_r;
	logic net_r;

	// Extra stage tames an enable that changes at any time
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			ena_s_r <= RST_LVL;
		else
			ena_s_r <= nif.ena;
	end

	// Bypass saves a cycle for enables already in step
	assign ena_in = (HAS_BYPASS && nif.bypass) ? nif.ena : ena_s_r; // [RL19]

	// Previous source level for the falling-edge detect
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			src_d_r <= RST_LVL;
		else
			src_d_r <= nif.src;
	end

	assign fall = src_d_r & ~nif.src;

	// Enable moves only when the source goes low, so no high is cut short
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			en_r <= RST_LVL;
		else if (fall)
			en_r <= ena_in & nif.used; // [RL18] [RL13]
	end

	// Unused or disabled network sits low
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			net_r <= RST_LVL;
		else
			net_r <= nif.src & en_r & nif.used; // [RL11] [RL12]
	end

	assign nif.net      = net_r;
	assign nif.en_state = en_r;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence src_fall_s;
		nif.src ##1 !nif.src;
	endsequence

	sequence en_change_s;
		$changed(en_r);
	endsequence

	unused_off_a: assert property (!nif.used |=> !nif.net) // [RL11]
		else $error("unused network drove a clock");
	fall_load_a: assert property (src_fall_s |=> en_r == $past(ena_in & nif.used)) // [RL18]
		else $error("enable not loaded on falling edge");
	en_only_fall_a: assert property (en_change_s |-> $past(fall)) // [RL18]
		else $error("enable moved without a falling edge");
	sync_stage_a: assert property ($rose(en_r) |-> ((HAS_BYPASS && $past(nif.bypass)) ? $past(nif.ena) : $past(nif.ena, 2))) // [RL19]
		else $error("enable latency wrong for stage setting");
	gated_high_a: assert property (nif.net |-> $past(en_r) && $past(nif.src)) // [RL12]
		else $error("network high while gated off");

endmodule // cnss_gate

/* File: cnss_clk_ctrl.sv */
`timescale 1ns/1ps
// What this block does
// RL1: One selector and gate per network
// RL2: Global source fixed or chosen at run time
// RL3: Run-time select works only in user mode
// RL4: Global inputs 0,1 take same-side clock pins
// RL5: Global input 2 takes corner counter 0/2
// RL6: Global input 3 takes corner counter 1/3
// RL7: Pinless side: input0 counter 4/6, input1 5
// RL8: Pins on inputs 0-1, PLLs 2-3, 2-bit pick
// RL9: Mixed sources should share one die side
// RL10: Regional source fixed by configuration only
// RL11: Unused networks held powered down
// RL12: Powered-down network delivers no clock
// RL13: Fabric enable gates each network synchronously
// RL14: Same enable gates PLL dedicated output pins
// RL15: Output cell picks fabric signal or clock
// RL16: PLL reaches 24 regional, 8 global networks
// RL17: Centre PLLs direct pins, corners 4:1 mux
// RL18: Enable registered on output clock fall
// RL19: Optional extra enable stage, bypass configurable
// RL20: Before user mode, configured source drives
module cnss_clk_ctrl
	import cnss_pkg::*;
#(
	parameter int  GLB_PER_SIDE = 4,  // Global networks per side
	parameter int  REG_PER_SIDE = 12, // Regional networks per side
	localparam int NG = NUM_SIDES * GLB_PER_SIDE,
	localparam int NR = NUM_SIDES * REG_PER_SIDE,
	localparam int NT = NG + NR,
	localparam int NPIN = NUM_SIDES * PINS_PER_SIDE,
	localparam int NCNT = NUM_PLL * CNT_PER_PLL
)(
	input  wire logic                    clk,                // 50 MHz
	input  wire logic                    rst_n,              // Sync reset
	input  wire logic                    user_mode_in,       // Async status
	input  wire logic [NPIN-1:0]         clk_pin,            // Clock pins
	input  wire logic [NCNT-1:0]         pll_cnt,            // PLL counters
	input  wire logic [NG*ROUTE_W-1:0]   cfg_glb_route,      // Input routes
	input  wire logic [NG*GSEL_W-1:0]    cfg_glb_static_sel, // Fixed pick
	input  wire logic [NG-1:0]           cfg_glb_dyn_mode,   // Run-time mode
	input  wire logic [NG*GSEL_W-1:0]    source_select_bits, // Fabric pick
	input  wire logic [NR*RSEL_W-1:0]    cfg_reg_sel,        // Regional pick
	input  wire logic [NT-1:0]           cfg_net_used,       // Net in use
	input  wire logic [NT-1:0]           cfg_sync_bypass,    // Skip stage
	input  wire logic [NT-1:0]           net_ena,            // Fabric enable
	input  wire logic [NUM_CORNER*2-1:0] cfg_corner_ref_sel, // 4:1 ref pick
	input  wire logic [NUM_PLL*PCNT_W-1:0] cfg_pll_out_cnt,  // Pin counter
	input  wire logic [NUM_PLL-1:0]      cfg_io_cell_sel,    // 1: clock
	input  wire logic [NUM_PLL-1:0]      fabric_to_pin,      // Fabric signal
	input  wire logic [NUM_PLL-1:0]      pll_out_ena,        // Pin enable
	output logic      [NG-1:0]           global_net,         // Global nets
	output logic      [NR-1:0]           regional_net,       // Regional nets
	output logic      [NT-1:0]           net_enabled,        // Gate state
	output logic      [NUM_PLL-1:0]      pll_dedicated_output_pin, // Pins
	output logic      [NUM_PLL-1:0]      pll_ref_clk,        // PLL refs
	output logic                         user_mode           // Synced mode
);
	logic [NPIN-1:0]    pin_q1_r;
	logic [NPIN-1:0]    pin_q2_r;
	logic [NCNT-1:0]    cnt_q1_r;
	logic [NCNT-1:0]    cnt_q2_r;
	logic               um_q1_r;
	logic               um_q2_r;
	logic [NUM_PLL-1:0] pll_pin_r;
	logic [NUM_PLL-1:0] pll_ref_r;
	logic [NUM_PLL-1:0] pll_pin_nxt;

	// Each corner PLL serves two sides; check its reach
	if (2 * GLB_PER_SIDE > PLL_MAX_GLB || 2 * REG_PER_SIDE > PLL_MAX_REG)
	begin : g_bad_reach
		$error("cnss_clk_ctrl: network count exceeds PLL reach"); // [RL16]
	end
	if (GLB_PER_SIDE < 1 || REG_PER_SIDE < 1)
	begin : g_bad_count
		$error("cnss_clk_ctrl: need at least one network per side");
	end

	// Pins, counters and the mode status arrive from outside this clock
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pin_q1_r <= '0;
			pin_q2_r <= '0;
			cnt_q1_r <= '0;
			cnt_q2_r <= '0;
			um_q1_r  <= RST_LVL;
			um_q2_r  <= RST_LVL;
		end
		else
		begin
			pin_q1_r <= clk_pin;
			pin_q2_r <= pin_q1_r;
			cnt_q1_r <= pll_cnt;
			cnt_q2_r <= cnt_q1_r;
			um_q1_r  <= user_mode_in;
			um_q2_r  <= um_q1_r;
		end
	end

	assign user_mode = um_q2_r;

	// One selector and gate per global network
	for (genvar g = 0; g < NG; g++)
	begin : g_glb // [RL1]
		localparam int SIDE = g / GLB_PER_SIDE;
		localparam int PA   = SIDE;
		localparam int PB   = (SIDE + 1) % NUM_CORNER;
		logic [GSEL_IN-1:0] cand;
		logic [FLD_W-1:0]   f0;
		logic [FLD_W-1:0]   f1;
		logic [FLD_W-1:0]   f2;
		logic [FLD_W-1:0]   f3;
		logic [2:0]         c0;
		cnss_net_if nif();

		assign f0 = cfg_glb_route[g*ROUTE_W+FLD_IN0 +: FLD_W];
		assign f1 = cfg_glb_route[g*ROUTE_W+FLD_IN1 +: FLD_W];
		assign f2 = cfg_glb_route[g*ROUTE_W+FLD_IN2 +: FLD_W];
		assign f3 = cfg_glb_route[g*ROUTE_W+FLD_IN3 +: FLD_W];

		if (SIDE == PINLESS_SIDE)
		begin : g_nopin
			// Counters only: bit 0 picks the PLL, bit 1 picks 6 over 4
			assign c0 = f0[1] ? 3'(POST_SCALER_OUT_6) : 3'(POST_SCALER_OUT_4);
			assign cand[0] = cnt_q2_r[(f0[0] ? PB : PA) * CNT_PER_PLL + c0]; // [RL7]
			assign cand[1] = cnt_q2_r[(f1[0] ? PB : PA) * CNT_PER_PLL + POST_SCALER_OUT_5]; // [RL7]
		end
		else
		begin : g_pin
			// Any of the four pins of this side
			assign c0 = '0;
			assign cand[0] = pin_q2_r[SIDE*PINS_PER_SIDE + f0]; // [RL4] [RL8]
			assign cand[1] = pin_q2_r[SIDE*PINS_PER_SIDE + f1]; // [RL4] [RL8]
		end

		// Corner counters: bit 0 picks the PLL, bit 1 the higher counter
		assign cand[2] = cnt_q2_r[(f2[0] ? PB : PA) * CNT_PER_PLL + (f2[1] ? POST_SCALER_OUT_2 : POST_SCALER_OUT_0)]; // [RL5] [RL8]
		assign cand[3] = cnt_q2_r[(f3[0] ? PB : PA) * CNT_PER_PLL + (f3[1] ? POST_SCALER_OUT_3 : POST_SCALER_OUT_1)]; // [RL6] [RL8]

		cnss_src_mux #(
			.N_IN   (GSEL_IN),
			.SEL_W  (GSEL_W),
			.DYN_OK (1'b1)
		) u_mux (
			.clk        (clk),
			.rst_n      (rst_n),
			.cand       (cand),
			.static_sel (cfg_glb_static_sel[g*GSEL_W +: GSEL_W]),
			.dyn_sel    (source_select_bits[g*GSEL_W +: GSEL_W]),
			.dyn_mode   (cfg_glb_dyn_mode[g]),
			.user_mode  (um_q2_r), // [RL3]
			.nif        (nif.mux)
		);

		cnss_gate #(
			.HAS_BYPASS (1'b1)
		) u_gate (
			.clk   (clk),
			.rst_n (rst_n),
			.nif   (nif.gate)
		);

		assign nif.used   = cfg_net_used[g];    // [RL11]
		assign nif.ena    = net_ena[g];         // [RL13]
		assign nif.bypass = cfg_sync_bypass[g]; // [RL19]
		assign global_net[g]  = nif.net;
		assign net_enabled[g] = nif.en_state;
	end

	// One fixed selector and gate per regional network
	for (genvar r = 0; r < NR; r++)
	begin : g_reg // [RL1]
		localparam int SIDE = r / REG_PER_SIDE;
		localparam int PA   = SIDE;
		localparam int PB   = (SIDE + 1) % NUM_CORNER;
		logic [RSEL_IN-1:0] cand;
		cnss_net_if nif();

		// Pinless side offers no pins; those candidates stay low
		if (SIDE == PINLESS_SIDE)
		begin : g_nopin
			assign cand[PINS_PER_SIDE-1:0] = '0;
		end
		else
		begin : g_pin
			assign cand[PINS_PER_SIDE-1:0] =
				pin_q2_r[SIDE*PINS_PER_SIDE +: PINS_PER_SIDE];
		end
		assign cand[4] = cnt_q2_r[PA*CNT_PER_PLL + POST_SCALER_OUT_0]; // [RL16]
		assign cand[5] = cnt_q2_r[PA*CNT_PER_PLL + POST_SCALER_OUT_1];
		assign cand[6] = cnt_q2_r[PB*CNT_PER_PLL + POST_SCALER_OUT_0];
		assign cand[7] = cnt_q2_r[PB*CNT_PER_PLL + POST_SCALER_OUT_1];

		// Fabric has no path to this select
		cnss_src_mux #(
			.N_IN   (RSEL_IN),
			.SEL_W  (RSEL_W),
			.DYN_OK (1'b0)
		) u_mux (
			.clk        (clk),
			.rst_n      (rst_n),
			.cand       (cand),
			.static_sel (cfg_reg_sel[r*RSEL_W +: RSEL_W]), // [RL10]
			.dyn_sel    ('0),
			.dyn_mode   (1'b0),
			.user_mode  (um_q2_r),
			.nif        (nif.mux)
		);

		cnss_gate #(
			.HAS_BYPASS (1'b1)
		) u_gate (
			.clk   (clk),
			.rst_n (rst_n),
			.nif   (nif.gate)
		);

		assign nif.used   = cfg_net_used[NG+r];    // [RL11]
		assign nif.ena    = net_ena[NG+r];         // [RL13]
		assign nif.bypass = cfg_sync_bypass[NG+r]; // [RL19]
		assign regional_net[r]   = nif.net;
		assign net_enabled[NG+r] = nif.en_state;
	end

	// Dedicated PLL output pins: same gate, no stage bypass
	for (genvar p = 0; p < NUM_PLL; p++)
	begin : g_pout
		logic [PCNT_W-1:0] cs;
		cnss_net_if nif();

		assign cs = cfg_pll_out_cnt[p*PCNT_W +: PCNT_W];
		// Counter select beyond the last counter yields a quiet pin
		assign nif.src = (cs < PCNT_W'(CNT_PER_PLL)) ?
			cnt_q2_r[p*CNT_PER_PLL + cs] : RST_LVL;
		assign nif.used   = 1'b1;
		assign nif.ena    = pll_out_ena[p]; // [RL14]
		assign nif.bypass = 1'b0;

		cnss_gate #(
			.HAS_BYPASS (1'b0)
		) u_gate (
			.clk   (clk),
			.rst_n (rst_n),
			.nif   (nif.gate)
		);

		// Output cell mux is set by configuration only
		assign pll_pin_nxt[p] = cfg_io_cell_sel[p] ? nif.net
			: fabric_to_pin[p]; // [RL15]
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			pll_pin_r <= '0;
		else
			pll_pin_r <= pll_pin_nxt; // [RL15] [RL14]
	end

	assign pll_dedicated_output_pin = pll_pin_r;

	// Corner PLL references: 4:1 over the pins of a side with pins
	for (genvar k = 0; k < NUM_CORNER; k++)
	begin : g_cref
		localparam int RSIDE = (k == PINLESS_SIDE) ? k + 1 : k;
		logic [1:0] rs;
		assign rs = cfg_corner_ref_sel[k*2 +: 2];

		always_ff @(posedge clk)
		begin
			if (!rst_n)
				pll_ref_r[k] <= RST_LVL;
			else
				pll_ref_r[k] <= pin_q2_r[RSIDE*PINS_PER_SIDE + rs]; // [RL17]
		end
	end

	// Centre PLLs hang straight off one pin group, no selection
	for (genvar c = 0; c < NUM_CENTER; c++)
	begin : g_ctr
		always_ff @(posedge clk)
		begin
			if (!rst_n)
				pll_ref_r[NUM_CORNER+c] <= RST_LVL;
			else
				pll_ref_r[NUM_CORNER+c] <=
					pin_q2_r[CENTER_REF_SIDE*PINS_PER_SIDE + c]; // [RL17]
		end
	end

	assign pll_ref_clk = pll_ref_r;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	io_cell_mux_a: assert property (##1 pll_dedicated_output_pin == $past(pll_pin_nxt)) // [RL15]
		else $error("output cell mux did not follow");
	center_ref_a: assert property (##1 pll_ref_clk[NUM_CORNER] == $past(pin_q2_r[CENTER_REF_SIDE*PINS_PER_SIDE])) // [RL17]
		else $error("centre PLL reference not from pin group");
	pin_fabric_a: assert property (!cfg_io_cell_sel[0] |=> pll_dedicated_output_pin[0] == $past(fabric_to_pin[0])) // [RL15]
		else $error("output cell ignored fabric signal");

	// Mode status passes exactly two stages, never fewer, so no
	// selector sees a half-settled level
	mode_sync_a: assert property ( // [RL3]
		##2 user_mode == $past(user_mode_in, 2))
		else $error("user mode not synced in two stages");

	// Corner PLL 0 sits on the pinless side, so it borrows side 1 pins
	corner0_ref_a: assert property ( // [RL17]
		##1 pll_ref_clk[0] ==
		$past(pin_q2_r[PINS_PER_SIDE + cfg_corner_ref_sel[1:0]]))
		else $error("corner PLL 0 reference not from its pin pick");

	// Corner PLL 3 picks among the pins of its own side
	corner3_ref_a: assert property ( // [RL17]
		##1 pll_ref_clk[3] ==
		$past(pin_q2_r[3*PINS_PER_SIDE + cfg_corner_ref_sel[7:6]]))
		else $error("corner PLL 3 reference not from its pin pick");

	// Second centre PLL is wired to the next pin of the same group
	centre1_ref_a: assert property ( // [RL17]
		##1 pll_ref_clk[NUM_CORNER+1] ==
		$past(pin_q2_r[CENTER_REF_SIDE*PINS_PER_SIDE + 1]))
		else $error("centre PLL 1 reference not from pin group");

	// Unused networks stay low whatever the source does
	glb_unused_a: assert property ( // [RL11]
		!cfg_net_used[0] |=> !global_net[0])
		else $error("unused global network drove a clock");
	reg_unused_a: assert property ( // [RL11]
		!cfg_net_used[NG] |=> !regional_net[0])
		else $error("unused regional network drove a clock");

	// With the cell set to clock, the pin shows only the gated clock
	pin_gated_a: assert property ( // [RL14]
		##1 ($past(cfg_io_cell_sel[0]) ->
		pll_dedicated_output_pin[0] == $past(g_pout[0].nif.net)))
		else $error("dedicated pin bypassed its gate");

endmodule // cnss_clk_ctrl

/* File: cnss_fabric_model.sv */
`timescale 1ns/1ps
// Fabric side: takes bench requests on the rise, launches on the fall,
// so the bench never races the launch and the block sees settled levels
module cnss_fabric_model (
	input  wire logic        clk,                // System clock
	input  wire logic        req_user,           // Wanted mode
	input  wire logic [31:0] req_sel,            // Wanted picks
	input  wire logic [63:0] req_ena,            // Wanted enables
	input  wire logic [5:0]  req_pin,            // Wanted pin data
	input  wire logic [5:0]  req_pena,           // Wanted pin enables
	output wire logic        user_mode_in,       // Mode status
	output wire logic [31:0] source_select_bits, // Run-time picks
	output wire logic [63:0] net_ena,            // Network enables
	output wire logic [5:0]  fabric_to_pin,      // Pin data
	output wire logic [5:0]  pll_out_ena         // Pin enables
);
	logic [108:0] cap_r = '0; // Requests seen on the rise
	logic [108:0] out_r = '0; // Levels launched on the fall
	// Capture
	always_ff @(posedge clk)
	begin
		cap_r <= {req_user, req_sel, req_ena, req_pin, req_pena};
	end
	// Launch half a cycle later
	always_ff @(negedge clk)
	begin
		out_r <= cap_r;
	end
	// Select and mode lines
	assign {user_mode_in, source_select_bits} = out_r[108:76];
	// Enables for networks and dedicated pins, plus fabric pin data
	assign {net_ena, fabric_to_pin, pll_out_ena} = out_r[75:0];
endmodule // cnss_fabric_model

/* File: tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
	num_errors++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
	end end
module tb_top;
	import cnss_pkg::*;
	logic         clk = 0;       // 50 MHz
	logic         rst_n = 0;     // Sync reset
	logic [15:0]  clk_pin = '0;  // Pins
	logic [41:0]  pll_cnt = '0;  // Counters
	logic [127:0] route = '0;    // Global routes
	logic [31:0]  ssel = '0;     // Fixed picks
	logic [15:0]  dmode = '0;    // Run-time mode
	logic [143:0] rsel = '0;     // Regional picks
	logic [63:0]  used = '0;     // Nets in use
	logic [63:0]  byp = '0;      // Stage bypass
	logic [7:0]   cref = '0;     // Corner ref pick
	logic [17:0]  pcnt = '0;     // Pin counter pick
	logic [5:0]   iosel = '0;    // Pin cell pick
	logic         r_user = 0;    // Requests to fabric
	logic [31:0]  r_sel = '0;
	logic [63:0]  r_ena = '0;
	logic [5:0]   r_pin = '0;
	logic [5:0]   r_pena = '0;
	wire logic        umi;
	wire logic [31:0] sbits;
	wire logic [63:0] nena;
	wire logic [5:0]  f2p;
	wire logic [5:0]  pena;
	logic [15:0] gnet;
	logic [47:0] rnet;
	logic [63:0] nen;
	logic [5:0]  ppin;
	logic [5:0]  pref;
	logic        umode;
	logic        obs;
	int num_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int run = 0;
	int okind = 0;
	int oidx = 0;
	bit mon_on = 0;

	cnss_fabric_model cnss_fabric_model_inst (.clk(clk), .req_user(r_user),
		.req_sel(r_sel), .req_ena(r_ena), .req_pin(r_pin),
		.req_pena(r_pena), .user_mode_in(umi), .source_select_bits(sbits),
		.net_ena(nena), .fabric_to_pin(f2p), .pll_out_ena(pena));
	cnss_clk_ctrl cnss_clk_ctrl_inst (.clk(clk), .rst_n(rst_n),
		.user_mode_in(umi), .clk_pin(clk_pin), .pll_cnt(pll_cnt),
		.cfg_glb_route(route), .cfg_glb_static_sel(ssel),
		.cfg_glb_dyn_mode(dmode), .source_select_bits(sbits),
		.cfg_reg_sel(rsel), .cfg_net_used(used), .cfg_sync_bypass(byp),
		.net_ena(nena), .cfg_corner_ref_sel(cref),
		.cfg_pll_out_cnt(pcnt), .cfg_io_cell_sel(iosel),
		.fabric_to_pin(f2p), .pll_out_ena(pena), .global_net(gnet),
		.regional_net(rnet), .net_enabled(nen),
		.pll_dedicated_output_pin(ppin), .pll_ref_clk(pref),
		.user_mode(umode));

	always #10 clk = ~clk;
	// One observed output, chosen per scenario
	always_comb
	begin
		case (okind)
			0: obs = gnet[oidx];
			1: obs = rnet[oidx];
			2: obs = ppin[oidx];
			default: obs = pref[oidx];
		endcase
	end
	// A gated pulse must be whole: high as long as its source half period
	always @(posedge clk)
	begin
		if (!mon_on)
			run = 0;
		else if (obs === 1'b1)
			run++;
		else if (run != 0)
		begin
			`CHK("pulse length", 8, run)
			run = 0;
		end
	end
	// Hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			num_errors++;
			final_report();
		end
	end

	task automatic final_report();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic go(int n);
		repeat (n) @(negedge clk);
	endtask
	// Chosen source gets v, every other source the opposite
	task automatic drive(bit pin, int idx, logic v);
		clk_pin = {16{~v}};
		pll_cnt = {42{~v}};
		if (pin)
			clk_pin[idx] = v;
		else
			pll_cnt[idx] = v;
	endtask
	// Prime one full period so the gate sees a fall, then check levels
	task automatic follow(bit pin, int idx, logic on, string nm);
		drive(pin, idx, 1'b1);
		go(8);
		drive(pin, idx, 1'b0);
		go(8);
		for (int i = 0; i < 4; i++)
		begin
			drive(pin, idx, ~i[0]);
			go(8);
			`CHK(nm, on & ~i[0], obs)
		end
	endtask

	// Global 4 on side 1: in0 pin 0, in1 pin 2, in2 PLL1 c0, in3 PLL2 c3
	task automatic t_static();
		okind = 0;
		oidx = 4;
		dmode[4] = 1;
		r_sel[9:8] = 2'd3;
		follow(1, 4, 1, "configured pick");
	endtask
	task automatic t_dyn();
		bit pins[4] = '{1, 1, 0, 0};
		int idx[4] = '{4, 6, 7, 17};
		r_user = 1;
		go(6);
		`CHK("user mode", 1'b1, umode)
		for (int s = 0; s < 4; s++)
		begin
			r_sel[9:8] = s[1:0];
			follow(pins[s], idx[s], 1, "run-time pick");
		end
		dmode[4] = 0;
		ssel[9:8] = 2'd1;
		follow(1, 6, 1, "fixed mode");
		ssel[9:8] = 2'd0;
	endtask
	// Global 0 on the pinless side: in0 PLL0 c6, in1 PLL1 c5
	task automatic t_pinless();
		oidx = 0;
		r_sel[1:0] = 2'd0;
		follow(0, 6, 1, "pinless in0");
		r_sel[1:0] = 2'd1;
		follow(0, 12, 1, "pinless in1");
	endtask
	// Regional 12 on side 1 ignores every run-time select
	task automatic t_regional();
		okind = 1;
		oidx = 12;
		r_sel = '1;
		rsel[38:36] = 3'd4;
		follow(0, 7, 1, "regional PLL");
		rsel[38:36] = 3'd0;
		follow(1, 4, 1, "regional pin");
		r_sel = '0;
	endtask
	task automatic t_unused();
		okind = 0;
		oidx = 4;
		used[4] = 0;
		follow(1, 4, 0, "unused net");
		`CHK("unused state", 1'b0, nen[4])
		used[4] = 1;
	endtask
	// Enable dropped while the source is low, restored mid-pulse, with and without the extra stage
	task automatic t_gate(bit b);
		byp[4] = b;
		mon_on = 1;
		fork
			repeat (6)
			begin
				drive(1, 4, 1'b1);
				go(8);
				drive(1, 4, 1'b0);
				go(8);
			end
			begin
				go(13);
				r_ena[4] = 0;
				go(37);
				r_ena[4] = 1;
			end
		join
		mon_on = 0;
		r_ena[4] = 0;
		follow(1, 4, 0, "gated off");
		`CHK("enable off", 1'b0, nen[4])
		r_ena[4] = 1;
		follow(1, 4, 1, "gated on");
		`CHK("enable on", 1'b1, nen[4])
	endtask
	// Dedicated pin of PLL1: fabric signal, then gated counter 2
	task automatic t_pllpin();
		okind = 2;
		oidx = 1;
		r_pin = 6'h02;
		go(8);
		`CHK("pin fabric high", 1'b1, obs)
		r_pin = 6'h00;
		go(8);
		`CHK("pin fabric low", 1'b0, obs)
		iosel[1] = 1;
		pcnt[5:3] = 3'd2;
		r_pena[1] = 1;
		follow(0, 9, 1, "pin clock");
		r_pena[1] = 0;
		follow(0, 9, 0, "pin gated");
	endtask
	// Corner PLL1 through its pin pick, centre PLL4 straight from pin
	task automatic t_ref();
		okind = 3;
		oidx = 1;
		cref[3:2] = 2'd2;
		follow(1, 6, 1, "corner ref");
		oidx = 4;
		follow(1, 8, 1, "centre ref");
	endtask

	initial
	begin
		route[39:32] = 8'hC8; // Same-side sources only
		route[7:0] = 8'h06;
		used[4] = 1;
		used[0] = 1;
		used[28] = 1;
		dmode[0] = 1;
		r_ena[4] = 1;
		r_ena[0] = 1;
		r_ena[28] = 1;
		repeat (3) @(posedge clk);
		@(negedge clk);
		`CHK("reset outputs", 1'b0, |{gnet, rnet, nen, ppin, pref, umode})
		rst_n = 1;
		go(4);
		t_static();
		t_dyn();
		t_pinless();
		t_regional();
		t_unused();
		t_gate(0);
		t_gate(1);
		t_pllpin();
		t_ref();
		final_report();
	end
endmodule // tb_top
